// File: include/lane_pkg.sv
// Constants shared by the lane input stage and its control decoder.
// Assumes a 32-bit APB register bus and 10-bit line characters.
package lane_pkg;
  // Lane word widths
  localparam int TMDS_W = 20;
  localparam int FRL_W  = 40;
  localparam int CHAR_W = 10;
  localparam int LANES  = 4;
  localparam int CTL_PER_PIX = 6;

  // Register byte offsets
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_STATUS  = 8'h04;
  localparam logic [7:0] OFF_CTLBITS = 8'h08;
  localparam logic [7:0] OFF_WORDCNT = 8'h0C;

  // Control register fields
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_FRL    = 1;
  localparam int CTRL_DVI    = 2;
  localparam logic [2:0] CONTROL_RESET = 3'h0;

  // Status register fields
  localparam int STAT_READY   = 0;
  localparam int STAT_RUN     = 1;
  localparam int STAT_ACTIVE  = 4;
  localparam int STAT_FRL     = 8;
  localparam int STAT_SUPPORT = 9;

  // Control characters and the two bits they carry
  localparam logic [9:0] CHAR_CTL_00 = 10'h354;
  localparam logic [9:0] CHAR_CTL_01 = 10'h0AB;
  localparam logic [9:0] CHAR_CTL_10 = 10'h154;
  localparam logic [9:0] CHAR_CTL_11 = 10'h2AB;

  // Operating states
  typedef enum logic [2:0] {
    ST_OFF  = 3'b001,
    ST_WAIT = 3'b010,
    ST_RUN  = 3'b100
  } run_state_e;
endpackage

// File: include/ctrl_char_if.sv
// Carrier between the lane stage and one control character decoder.
// Assumes the character is stable whenever the lane stage samples it.
interface ctrl_char_if;
  logic [9:0] char_word;
  logic [1:0] ctl_bits;
  logic       is_ctrl;
  modport decoder (input char_word, output ctl_bits, output is_ctrl);
  modport user    (output char_word, input ctl_bits, input is_ctrl);
endinterface

// File: src/ctrl_decode.sv
// Decoder of one 10-bit control character into two control bits.
// Assumes a purely combinational use inside the lane stage.
module ctrl_decode (
  // Character in, bits out
  ctrl_char_if.decoder port_c
);
  wire hit_00 = port_c.char_word == lane_pkg::CHAR_CTL_00;
  wire hit_01 = port_c.char_word == lane_pkg::CHAR_CTL_01;
  wire hit_10 = port_c.char_word == lane_pkg::CHAR_CTL_10;
  wire hit_11 = port_c.char_word == lane_pkg::CHAR_CTL_11;

  // Bits are {second, first} control bit of the channel
  assign port_c.is_ctrl  = hit_00 | hit_01 | hit_10 | hit_11;
  assign port_c.ctl_bits = {hit_10 | hit_11, hit_01 | hit_11};
endmodule

// File: src/sink_lane_input_mapping.sv
// Receive lane input stage: lane capture, mode mapping, DVI control bits.
// Assumes lane clocks far slower than pclk and APB master on pclk.

// Summary of operation
// RULE_01 - Without FRL support each lane word is 20 bits wide.
// RULE_02 - With FRL support each lane word is 40 bits wide.
// RULE_03 - In TMDS mode only the low 20 bits of each word are used.
// RULE_04 - In FRL mode all 40 bits of each active lane are used.
// RULE_05 - Blue, green, red inputs carry channel or lane 0, 1, 2.
// RULE_06 - Clock lane input ignored in TMDS, used as lane 3 in FRL.
// RULE_07 - Ready input comes from transceiver reset controller; core runs only when set.
// RULE_08 - DVI mode outputs four control bits per pixel from green and red, in a six-bit field.
// RULE_09 - Lanes wired straight to transceivers, or through FIFO and oversampling.
module sink_lane_input_mapping #(
  parameter bit SUPPORT_FRL = 1'b1,
  localparam int LANE_W = SUPPORT_FRL ? lane_pkg::FRL_W : lane_pkg::TMDS_W,
  localparam int PIX_N  = lane_pkg::TMDS_W / lane_pkg::CHAR_W
) (
  // Clock and reset
  input  wire logic                               pclk,
  input  wire logic                               presetn,
  // APB slave
  input  wire logic [7:0]                         paddr,
  input  wire logic                               psel,
  input  wire logic                               penable,
  input  wire logic                               pwrite,
  input  wire logic [31:0]                        pwdata,
  output logic      [31:0]                        prdata,
  output logic                                    pready,
  output logic                                    pslverr,
  // Transceiver lanes and their clocks
  input  wire logic [LANE_W-1:0]                  blue_in,
  input  wire logic [LANE_W-1:0]                  green_in,
  input  wire logic [LANE_W-1:0]                  red_in,
  input  wire logic [LANE_W-1:0]                  clock_lane_in,
  input  wire logic [lane_pkg::LANES-1:0]         link_speed_clock,
  input  wire logic                               ready_to_operate,
  // Mapped lane words
  output logic [lane_pkg::LANES-1:0][LANE_W-1:0]  lane_word,
  output logic [lane_pkg::LANES-1:0]              lane_valid,
  // Decoder status
  output logic [PIX_N*lane_pkg::CTL_PER_PIX-1:0]  ctrl,
  output logic                                    dvi_mode,
  output logic                                    running
);
  localparam int L = lane_pkg::LANES;
  localparam logic [LANE_W-1:0] TMDS_MASK = LANE_W'({lane_pkg::TMDS_W{1'b1}});

  // Raw lane words, index 0 blue through 3 clock lane
  wire [L-1:0][LANE_W-1:0] raw_word;
  assign raw_word = {clock_lane_in, red_in, green_in, blue_in}; // RULE_05 RULE_01 RULE_02

  // Synchronisers
  logic [L-1:0]             lclk_s1_q;
  logic [L-1:0]             lclk_s2_q;
  logic [L-1:0]             lclk_s3_q;
  logic [L-1:0][LANE_W-1:0] data_s1_q;
  logic [L-1:0][LANE_W-1:0] data_s2_q;
  logic                     rdy_s1_q;
  logic                     rdy_s2_q;

  // Register state
  logic [2:0]               control_q;
  logic [31:0]              wordcnt_q;
  logic [31:0]              prdata_q;
  logic                     pready_q;
  logic                     pslverr_q;
  lane_pkg::run_state_e     state_q;
  lane_pkg::run_state_e     state_d;

  // Output registers
  logic [L-1:0][LANE_W-1:0] lane_word_q;
  logic [L-1:0]             lane_valid_q;
  logic                     dvi_mode_q;
  logic                     running_q;
  logic [1:0]               ctl_q [PIX_N][2];

  // Ready synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdy_s1_q <= 1'b0;
      rdy_s2_q <= 1'b0;
    end else begin
      rdy_s1_q <= ready_to_operate;
      rdy_s2_q <= rdy_s1_q;
    end
  end

  // Lane data sampled on pclk; upstream path decides direct or oversampled
  genvar gl;
  generate
    for (gl = 0; gl < L; gl++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          lclk_s1_q[gl] <= 1'b0;
          lclk_s2_q[gl] <= 1'b0;
          lclk_s3_q[gl] <= 1'b0;
          data_s1_q[gl] <= '0;
          data_s2_q[gl] <= '0;
        end else begin
          lclk_s1_q[gl] <= link_speed_clock[gl];
          lclk_s2_q[gl] <= lclk_s1_q[gl];
          lclk_s3_q[gl] <= lclk_s2_q[gl];
          data_s1_q[gl] <= raw_word[gl]; // RULE_09
          data_s2_q[gl] <= data_s1_q[gl];
        end
      end
    end
  endgenerate

  // Falling link edge: mid-period, word long settled
  wire [L-1:0] link_fall = lclk_s3_q & ~lclk_s2_q;

  // Mode selection
  wire ctl_enable = control_q[lane_pkg::CTRL_ENABLE];
  wire frl_eff    = SUPPORT_FRL & control_q[lane_pkg::CTRL_FRL]; // RULE_01 RULE_02
  wire dvi_sel    = control_q[lane_pkg::CTRL_DVI] & ~frl_eff;
  wire run        = state_q == lane_pkg::ST_RUN;

  // Operating state
  always_comb begin
    case (state_q)
      lane_pkg::ST_OFF:  state_d = ctl_enable ? lane_pkg::ST_WAIT : lane_pkg::ST_OFF;
      lane_pkg::ST_WAIT: state_d = !ctl_enable ? lane_pkg::ST_OFF :
                                   rdy_s2_q ? lane_pkg::ST_RUN : lane_pkg::ST_WAIT; // RULE_07
      lane_pkg::ST_RUN:  state_d = !ctl_enable ? lane_pkg::ST_OFF :
                                   !rdy_s2_q ? lane_pkg::ST_WAIT : lane_pkg::ST_RUN; // RULE_07
      default:           state_d = lane_pkg::ST_OFF;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= lane_pkg::ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // Lane activity and consumed words
  wire [L-1:0]             lane_active;
  wire [L-1:0][LANE_W-1:0] used_word;
  generate
    for (gl = 0; gl < L; gl++) begin : g_map
      if (gl == L - 1) begin : g_clk_lane
        assign lane_active[gl] = run & frl_eff; // RULE_06
      end else begin : g_colour
        assign lane_active[gl] = run; // RULE_05
      end
      assign used_word[gl] = frl_eff ? data_s2_q[gl] : (data_s2_q[gl] & TMDS_MASK); // RULE_03 RULE_04
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          lane_word_q[gl]  <= '0;
          lane_valid_q[gl] <= 1'b0;
        end else begin
          lane_valid_q[gl] <= link_fall[gl] & lane_active[gl];
          if (!lane_active[gl]) begin
            lane_word_q[gl] <= '0;
          end else if (link_fall[gl]) begin
            lane_word_q[gl] <= used_word[gl];
          end
        end
      end
    end
  endgenerate

  // DVI control bits from green (ch 0) and red (ch 1)
  genvar gp;
  genvar gc;
  generate
    for (gp = 0; gp < PIX_N; gp++) begin : g_pix
      for (gc = 0; gc < 2; gc++) begin : g_ch
        ctrl_char_if cc ();
        ctrl_decode u_dec (
          .port_c (cc.decoder)
        );
        assign cc.char_word = data_s2_q[gc+1][gp*lane_pkg::CHAR_W +: lane_pkg::CHAR_W];
        wire take = run & dvi_sel & link_fall[gc+1] & cc.is_ctrl;
        always_ff @(posedge pclk or negedge presetn) begin
          if (!presetn) begin
            ctl_q[gp][gc] <= 2'h0;
          end else if (!run || !dvi_sel) begin
            ctl_q[gp][gc] <= 2'h0;
          end else if (take) begin
            ctl_q[gp][gc] <= cc.ctl_bits; // RULE_08
          end
        end
      end
      // Bits 5..2 are control bits three..zero, 1..0 reserved zero
      assign ctrl[gp*lane_pkg::CTL_PER_PIX +: lane_pkg::CTL_PER_PIX] =
        {ctl_q[gp][1], ctl_q[gp][0], 2'h0}; // RULE_08
    end
  endgenerate

  // APB decode
  wire        setup_ph  = psel & ~penable;
  wire        access_ok = psel & penable & pready_q;
  wire        wr_ok     = access_ok & pwrite;
  wire        hit_ctl   = paddr == lane_pkg::OFF_CONTROL;
  wire        hit_stat  = paddr == lane_pkg::OFF_STATUS;
  wire        hit_bits  = paddr == lane_pkg::OFF_CTLBITS;
  wire        hit_cnt   = paddr == lane_pkg::OFF_WORDCNT;
  wire        hit_any   = hit_ctl | hit_stat | hit_bits | hit_cnt;
  wire [31:0] status_w;
  wire [31:0] rd_mux;
  assign status_w = {22'h0, SUPPORT_FRL, frl_eff, lane_active, 2'h0, run, rdy_s2_q};
  assign rd_mux   = hit_ctl  ? {29'h0, control_q} :
                    hit_stat ? status_w :
                    hit_bits ? 32'(ctrl) :
                    hit_cnt  ? wordcnt_q : 32'h0;

  // One wait-free access: answer ready in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end else begin
      pready_q  <= setup_ph;
      pslverr_q <= setup_ph & ~hit_any;
      if (setup_ph) begin
        prdata_q <= pwrite ? 32'h0 : rd_mux;
      end
    end
  end

  // Control register and captured word counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_q <= lane_pkg::CONTROL_RESET;
    end else if (wr_ok && hit_ctl) begin
      control_q <= pwdata[2:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wordcnt_q <= 32'h0;
    end else if (link_fall[0] && lane_active[0]) begin
      wordcnt_q <= wordcnt_q + 32'h1;
    end else if (wr_ok && hit_cnt) begin
      wordcnt_q <= 32'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dvi_mode_q <= 1'b0;
      running_q  <= 1'b0;
    end else begin
      dvi_mode_q <= run & dvi_sel;
      running_q  <= state_d == lane_pkg::ST_RUN;
    end
  end

  assign prdata     = prdata_q;
  assign pready     = pready_q;
  assign pslverr    = pslverr_q;
  assign lane_word  = lane_word_q;
  assign lane_valid = lane_valid_q;
  assign dvi_mode   = dvi_mode_q;
  assign running    = running_q;
endmodule

// File: sim/lane_xcvr_model.sv
// Transceiver side model: link clocks, lane words, ready flag.
// Assumes the bench sets the words and starts or stops the link.
module lane_xcvr_model (
  // Bench control
  input  wire logic        link_on,
  input  wire logic        lock_req,
  input  wire logic [39:0] wb,
  input  wire logic [39:0] wg,
  input  wire logic [39:0] wr,
  input  wire logic [39:0] wc,
  // Towards the block
  output logic [3:0]       link_speed_clock,
  output logic [39:0]      blue_in,
  output logic [39:0]      green_in,
  output logic [39:0]      red_in,
  output logic [39:0]      clock_lane_in,
  output logic             ready_to_operate
);
  timeunit 1ns;
  timeprecision 1ns;
  logic lclk = 1'b0;
  assign link_speed_clock = {4{lclk}};
  // Link clock stands still while the link is off
  initial begin
    #37;
    forever #200 if (link_on) lclk = ~lclk;
  end
  // Lane words straight from the receivers
  initial begin
    {blue_in, green_in, red_in, clock_lane_in} = '0;
    forever @(posedge lclk) {blue_in, green_in, red_in, clock_lane_in} <= {wb, wg, wr, wc};
  end
  // Ready follows lock after a settling delay
  initial begin
    ready_to_operate = 1'b0;
    forever @(lock_req) ready_to_operate <= #1000 lock_req;
  end
endmodule

// File: sim/lane_map_asserts.sv
// Checker for the lane input stage, on top-level ports only.
// Assumes mode bits are set by APB writes to the control offset.
module lane_map_asserts #(
  parameter bit SUPPORT_FRL = 1'b1,
  localparam int LW = SUPPORT_FRL ? lane_pkg::FRL_W : lane_pkg::TMDS_W
) (
  input wire logic                             pclk,
  input wire logic                             presetn,
  input wire logic [7:0]                       paddr,
  input wire logic                             psel,
  input wire logic                             penable,
  input wire logic                             pwrite,
  input wire logic [31:0]                      pwdata,
  input wire logic                             pready,
  input wire logic [LW-1:0]                    blue_in,
  input wire logic [LW-1:0]                    green_in,
  input wire logic [LW-1:0]                    red_in,
  input wire logic [LW-1:0]                    clock_lane_in,
  input wire logic                             ready_to_operate,
  input wire logic [lane_pkg::LANES-1:0][LW-1:0] lane_word,
  input wire logic [lane_pkg::LANES-1:0]       lane_valid,
  input wire logic [11:0]                      ctrl,
  input wire logic                             dvi_mode,
  input wire logic                             running
);
  logic mode_frl_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) mode_frl_q <= 1'b0;
    else if (psel && penable && pready && pwrite && paddr == lane_pkg::OFF_CONTROL) mode_frl_q <= pwdata[1];
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence frl_cap_s(k);
    lane_valid[k] && mode_frl_q;
  endsequence
  sequence ready_drop_s;
    $fell(ready_to_operate);
  endsequence
  lane_width_a: assert property (lane_valid[2] |->
    lane_word[2] == ($past(red_in, 2) & (mode_frl_q ? {LW{1'b1}} : LW'(20'hFFFFF))))
    else $error("lane width wrong");
  tmds_low_a: assert property (lane_valid[0] && !mode_frl_q |-> lane_word[0] == ($past(blue_in, 2) & LW'(20'hFFFFF)))
    else $error("tmds word not low bits");
  frl_blue_a: assert property (frl_cap_s(0) |-> lane_word[0] == $past(blue_in, 2))
    else $error("lane 0 word wrong");
  frl_green_a: assert property (frl_cap_s(1) |-> lane_word[1] == $past(green_in, 2))
    else $error("lane 1 word wrong");
  frl_red_a: assert property (frl_cap_s(2) |-> lane_word[2] == $past(red_in, 2))
    else $error("lane 2 word wrong");
  lane_three_a: assert property (frl_cap_s(3) |-> lane_word[3] == $past(clock_lane_in, 2))
    else $error("lane 3 word wrong");
  lane_three_off_a: assert property (lane_valid[3] |-> mode_frl_q)
    else $error("lane 3 used in tmds");
  ctrl_rsv_a: assert property ((ctrl & 12'h0C3) == 12'h000)
    else $error("reserved ctrl bits set");
  ctrl_red_a: assert property (dvi_mode && lane_valid[2] && lane_word[2][19:0] == {2{lane_pkg::CHAR_CTL_11}}
    |-> ##[0:1] ctrl[5:4] == 2'b11 && ctrl[11:10] == 2'b11)
    else $error("red ctrl bits wrong");
  ctrl_green_a: assert property (dvi_mode && lane_valid[1] && lane_word[1][19:0] == {2{lane_pkg::CHAR_CTL_00}}
    |-> ##[0:1] ctrl[3:2] == 2'b00 && ctrl[9:8] == 2'b00)
    else $error("green ctrl bits wrong");
  ready_stop_a: assert property (ready_drop_s |-> ##[1:4] !running)
    else $error("still running without ready");
endmodule

bind sink_lane_input_mapping lane_map_asserts #(.SUPPORT_FRL(SUPPORT_FRL)) lane_map_asserts_i (.pclk, .presetn,
  .paddr, .psel, .penable, .pwrite, .pwdata, .pready, .blue_in, .green_in, .red_in, .clock_lane_in,
  .ready_to_operate, .lane_word, .lane_valid, .ctrl, .dvi_mode, .running);

// File: sim/tb.sv
// Self-checking bench for the lane input stage built with FRL support.
// Assumes the transceiver model makes link clocks and the ready flag.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, dvi_mode, running, er, link_on, lock_req;
  logic ready_to_operate;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, cnt;
  logic [39:0] wb, wg, wr, wc, blue_in, green_in, red_in, clock_lane_in;
  logic [3:0] link_speed_clock, lane_valid;
  logic [3:0][39:0] lane_word;
  logic [11:0] ctrl;
  int errors, total_checks;
  sink_lane_input_mapping #(.SUPPORT_FRL(1'b1)) sink_lane_input_mapping_i (.pclk, .presetn, .paddr, .psel,
    .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .blue_in, .green_in, .red_in, .clock_lane_in,
    .link_speed_clock, .ready_to_operate, .lane_word, .lane_valid, .ctrl, .dvi_mode, .running);
  lane_xcvr_model lane_xcvr_model_i (.link_on, .lock_req, .wb, .wg, .wr, .wc, .link_speed_clock, .blue_in,
    .green_in, .red_in, .clock_lane_in, .ready_to_operate);
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      errors++;
      wrap_up();
    end
  endtask
  // Mode change with the link stopped, so no capture straddles it
  task automatic set_mode(input logic [31:0] v);
    link_on <= 1'b0;
    repeat (12) @(posedge pclk);
    apb(1'b1, lane_pkg::OFF_CONTROL, v);
    link_on <= 1'b1;
  endtask
  task automatic cap(input int n);
    for (int t = 0; t < 400 && n > 0; t++) begin
      @(posedge pclk);
      if (lane_valid[0] === 1'b1) n--;
    end
    if (n > 0) begin
      errors++;
      wrap_up();
    end
  endtask
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  initial begin
    repeat (50000) @(posedge pclk);
    errors++;
    wrap_up();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, link_on, lock_req} = '0;
    {wb, wg, wr, wc} = {40'hFF_FFF1_2345, 40'hEE_EEE6_789A, 40'hDD_DDDB_CDEF, 40'hCC_CCC5_5555};
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, lane_pkg::OFF_CONTROL, 32'h0);
    chk(rd, lane_pkg::CONTROL_RESET);
    apb(1'b0, 8'h10, 32'h0);
    chk({er, rd}, 33'h1_0000_0000);
    apb(1'b0, lane_pkg::OFF_STATUS, 32'h0);
    chk(rd[lane_pkg::STAT_SUPPORT], 1'b1);
    lock_req <= 1'b1;
    set_mode(32'h1);
    cap(3);
    chk(lane_word[0], 40'h1_2345);
    chk(lane_word[1], 40'h6_789A);
    chk(lane_word[2], 40'hB_CDEF);
    chk(lane_word[3], 40'h0);
    $display("tmds lanes done");
    set_mode(32'h3);
    cap(3);
    chk(lane_word[0], wb);
    chk(lane_word[1], wg);
    chk(lane_word[2], wr);
    chk(lane_word[3], wc);
    $display("frl lanes done");
    set_mode(32'h5);
    for (int i = 0; i < 2; i++) begin
      wg <= 40'({2{i ? lane_pkg::CHAR_CTL_11 : lane_pkg::CHAR_CTL_00}});
      wr <= 40'({2{i ? lane_pkg::CHAR_CTL_00 : lane_pkg::CHAR_CTL_11}});
      cap(3);
      chk(ctrl, i ? 12'h30C : 12'hC30);
      chk(dvi_mode, 1'b1);
      apb(1'b0, lane_pkg::OFF_CTLBITS, 32'h0);
      chk(rd, i ? 32'h30C : 32'hC30);
    end
    $display("dvi control done");
    lock_req <= 1'b0;
    for (int t = 0; t < 60 && running !== 1'b0; t++) @(posedge pclk);
    repeat (2) @(posedge pclk);
    chk(running, 1'b0);
    chk(lane_word[0], 40'h0);
    apb(1'b0, lane_pkg::OFF_WORDCNT, 32'h0);
    cnt = rd;
    chk(cnt != 32'h0, 1'b1);
    repeat (40) @(posedge pclk);
    apb(1'b0, lane_pkg::OFF_WORDCNT, 32'h0);
    chk(rd, cnt);
    apb(1'b1, lane_pkg::OFF_WORDCNT, 32'h0);
    apb(1'b0, lane_pkg::OFF_WORDCNT, 32'h0);
    chk(rd, 32'h0);
    $display("ready loss done");
    link_on <= 1'b0;
    wrap_up();
  end
endmodule
